//--- ipv_pkg.sv
// Purpose: shared constants for the interrupt priority and vectoring block
// Assumes: eleven sources, indexed by their polling rank (index 0 is polled first)
// Notes: vector table and level encoding live here so both design files agree
package ipv_pkg;
	localparam int NUM_SRC = 11;
	localparam int SRC_W = 4;
	localparam int LVL_W = 2;
	localparam int NUM_LVL = 4;
	localparam int VEC_W = 16;
	localparam int CNT_W = 16;
	localparam int PCA_MODULES = 5;
	// source index = polling rank minus one
	localparam logic [SRC_W-1:0] SRC_EXT0 = 4'h0;
	localparam logic [SRC_W-1:0] SRC_TMR0 = 4'h1;
	localparam logic [SRC_W-1:0] SRC_EXT1 = 4'h2;
	localparam logic [SRC_W-1:0] SRC_TMR1 = 4'h3;
	localparam logic [SRC_W-1:0] SRC_PCA = 4'h4;
	localparam logic [SRC_W-1:0] SRC_UART = 4'h5;
	localparam logic [SRC_W-1:0] SRC_TMR2 = 4'h6;
	localparam logic [SRC_W-1:0] SRC_CAN = 4'h7;
	localparam logic [SRC_W-1:0] SRC_ADC = 4'h8;
	localparam logic [SRC_W-1:0] SRC_CANTMR = 4'h9;
	localparam logic [SRC_W-1:0] SRC_SPI = 4'ha;
	localparam logic [VEC_W-1:0] VECTOR_TABLE [NUM_SRC] = '{
		16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033, 16'h0023,
		16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
	localparam logic [VEC_W-1:0] VECTOR_RESET = 16'h0000;
	localparam logic [LVL_W-1:0] LEVEL_LOWEST = 2'h0;
	localparam logic [LVL_W-1:0] LEVEL_HIGHEST = 2'h3;
	localparam logic [NUM_LVL-1:0] ACTIVE_RESET = 4'h0;
endpackage

//--- ipv_pca_if.sv
// Purpose: carrier between the vectoring top and one counter-array timer module
// Assumes: all signals on the single system clock
// Notes: the top owns counter, capture and mode bits; the timer owns flag and request
`timescale 1ns/1ps
interface ipv_pca_if;
	logic [ipv_pkg::CNT_W-1:0] count;
	logic [ipv_pkg::CNT_W-1:0] capture;
	logic comparator_enable;
	logic flag_on_equal;
	logic irq_enable;
	logic flag_clear;
	logic event_flag;
	logic irq;
	modport timer (
		input count, capture, comparator_enable, flag_on_equal, irq_enable, flag_clear,
		output event_flag, irq
	);
	modport owner (
		output count, capture, comparator_enable, flag_on_equal, irq_enable, flag_clear,
		input event_flag, irq
	);
endinterface

//--- ipv_pca_timer.sv
// Purpose: one counter-array module in 16-bit software timer mode
// Assumes: counter and capture values are stable, same-clock registers
// Notes: flag set beats a clear in the same cycle so no match is lost
`timescale 1ns/1ps
module ipv_pca_timer (
	// system
	input wire logic clock,
	input wire logic rst,
	// link to the vectoring top
	ipv_pca_if.timer pca
);
	logic event_flag;
	logic next_event_flag;
	logic irq;
	logic next_irq;
	logic timer_mode;
	logic match;

	always_comb
	begin
		timer_mode = pca.comparator_enable & pca.flag_on_equal;
		match = timer_mode && (pca.count == pca.capture);
		next_event_flag = event_flag;
		if (pca.flag_clear)
			next_event_flag = 1'b0;
		if (match)
			next_event_flag = 1'b1;
		// request only while both the flag and its enable stand
		next_irq = next_event_flag & pca.irq_enable;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			event_flag <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			event_flag <= next_event_flag;
			irq <= next_irq;
		end
	end

	assign pca.event_flag = event_flag;
	assign pca.irq = irq;

	a_match_sets_flag: assert property (@(posedge clock) disable iff (rst)
		(pca.comparator_enable && pca.flag_on_equal && pca.count == pca.capture)
		|=> event_flag)
		else $error("timer match did not set the event flag");
	a_irq_needs_both: assert property (@(posedge clock) disable iff (rst)
		irq |-> $past(next_event_flag) && $past(pca.irq_enable))
		else $error("timer request without flag and enable");
endmodule // ipv_pca_timer

//--- ipv_top.sv
// Purpose: interrupt priority resolution and vectoring for an 8-bit core
// Assumes: peripheral flags are same-clock levels; external requests are pins
// Notes: nested service tracked as a mask of active levels, one bit per level
`timescale 1ns/1ps
module ipv_top #(
	parameter int PCA_MODULES = ipv_pkg::PCA_MODULES
) (
	// system
	input wire logic clock,
	input wire logic rst,
	// external request pins, active high after the pad
	input wire logic ext_irq_zero,
	input wire logic ext_irq_one,
	// timer and peripheral flags
	input wire logic timer_zero_overflow,
	input wire logic timer_one_overflow,
	input wire logic timer_two_overflow,
	input wire logic uart_rx_done_flag,
	input wire logic uart_tx_done_flag,
	input wire logic can_send_ok,
	input wire logic can_recv_ok,
	input wire logic can_fault_flag,
	input wire logic can_buffer_overrun,
	input wire logic converter_done_flag,
	input wire logic can_timer_wrap_flag,
	input wire logic spi_irq_flag,
	// counter array
	input wire logic pca_counter_overflow_flag,
	input wire logic [ipv_pkg::CNT_W-1:0] pca_counter,
	input wire logic [PCA_MODULES*ipv_pkg::CNT_W-1:0] pca_capture,
	input wire logic [PCA_MODULES-1:0] comparator_enable,
	input wire logic [PCA_MODULES-1:0] flag_on_equal,
	input wire logic [PCA_MODULES-1:0] pca_module_irq_enable,
	input wire logic [PCA_MODULES-1:0] pca_flag_clear,
	output logic [PCA_MODULES-1:0] pca_module_event_flag,
	// enables and priorities, indexed by polling rank minus one
	input wire logic global_enable,
	input wire logic [ipv_pkg::NUM_SRC-1:0] source_enable,
	input wire logic [ipv_pkg::NUM_SRC-1:0] priority_high_bit,
	input wire logic [ipv_pkg::NUM_SRC-1:0] priority_low_bit,
	// core handshake
	input wire logic handler_return,
	output logic vector_valid,
	output logic [ipv_pkg::VEC_W-1:0] vector_addr,
	output logic [ipv_pkg::SRC_W-1:0] accepted_source,
	output logic [ipv_pkg::LVL_W-1:0] active_level,
	output logic in_service
);
	localparam int N = ipv_pkg::NUM_SRC;

	// highest set bit of a level mask
	function automatic logic [ipv_pkg::LVL_W-1:0] top_level(
		input logic [ipv_pkg::NUM_LVL-1:0] mask
	);
		logic [ipv_pkg::LVL_W-1:0] r;
		r = ipv_pkg::LEVEL_LOWEST;
		for (int k = 0; k < ipv_pkg::NUM_LVL; k++)
			if (mask[k])
				r = ipv_pkg::LVL_W'(k);
		return r;
	endfunction

	// external pins cross into the clock domain first
	logic [1:0] ext_meta;
	logic [1:0] ext_sync;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ext_meta <= 2'h0;
			ext_sync <= 2'h0;
		end
		else
		begin
			ext_meta <= {ext_irq_one, ext_irq_zero};
			ext_sync <= ext_meta;
		end
	end

	// counter-array timer modules
	logic [PCA_MODULES-1:0] pca_irq;
	logic [PCA_MODULES-1:0] pca_flag;
	genvar g;
	generate
		for (g = 0; g < PCA_MODULES; g++)
		begin : gen_pca
			ipv_pca_if link ();
			assign link.count = pca_counter;
			assign link.capture = pca_capture[g*ipv_pkg::CNT_W +: ipv_pkg::CNT_W];
			assign link.comparator_enable = comparator_enable[g];
			assign link.flag_on_equal = flag_on_equal[g];
			assign link.irq_enable = pca_module_irq_enable[g];
			assign link.flag_clear = pca_flag_clear[g];
			assign pca_irq[g] = link.irq;
			assign pca_flag[g] = link.event_flag;
			ipv_pca_timer u_timer (
				.clock(clock),
				.rst(rst),
				.pca(link)
			);
		end
	endgenerate
	assign pca_module_event_flag = pca_flag;

	// request gathering and eligibility
	logic [N-1:0] request;
	logic [N-1:0] eligible;
	logic [ipv_pkg::LVL_W-1:0] src_level [N];
	always_comb
	begin
		request = '0;
		request[ipv_pkg::SRC_EXT0] = ext_sync[0];
		request[ipv_pkg::SRC_TMR0] = timer_zero_overflow;
		request[ipv_pkg::SRC_EXT1] = ext_sync[1];
		request[ipv_pkg::SRC_TMR1] = timer_one_overflow;
		request[ipv_pkg::SRC_PCA] = pca_counter_overflow_flag | (|pca_irq);
		request[ipv_pkg::SRC_UART] = uart_rx_done_flag | uart_tx_done_flag;
		request[ipv_pkg::SRC_TMR2] = timer_two_overflow;
		request[ipv_pkg::SRC_CAN] = can_send_ok | can_recv_ok | can_fault_flag
			| can_buffer_overrun;
		request[ipv_pkg::SRC_ADC] = converter_done_flag;
		request[ipv_pkg::SRC_CANTMR] = can_timer_wrap_flag;
		request[ipv_pkg::SRC_SPI] = spi_irq_flag;
		for (int i = 0; i < N; i++)
		begin
			src_level[i] = {priority_high_bit[i], priority_low_bit[i]};
			eligible[i] = request[i] & source_enable[i] & global_enable;
		end
	end

	// winner: highest level, earliest rank on a tie
	logic win_found;
	logic [ipv_pkg::SRC_W-1:0] win_src;
	logic [ipv_pkg::LVL_W-1:0] win_level;
	always_comb
	begin
		win_found = 1'b0;
		win_src = ipv_pkg::SRC_EXT0;
		win_level = ipv_pkg::LEVEL_LOWEST;
		for (int i = 0; i < N; i++)
		begin
			// strict compare keeps the earlier rank on equal levels
			if (eligible[i] && (!win_found || src_level[i] > win_level))
			begin
				win_found = 1'b1;
				win_src = ipv_pkg::SRC_W'(i);
				win_level = src_level[i];
			end
		end
	end

	// checker helpers, reached by another route than the winner search above
	logic [ipv_pkg::NUM_LVL-1:0] lvl_seen;
	logic [N-1:0] tie_before;
	always_comb
	begin
		lvl_seen = '0;
		tie_before = '0;
		for (int i = 0; i < N; i++)
		begin
			if (eligible[i])
				lvl_seen[{priority_high_bit[i], priority_low_bit[i]}] = 1'b1;
			for (int j = 0; j < i; j++)
				if (eligible[j] && priority_high_bit[j] == priority_high_bit[i]
					&& priority_low_bit[j] == priority_low_bit[i])
					tie_before[i] = 1'b1;
		end
	end

	// service state
	logic [ipv_pkg::NUM_LVL-1:0] active_mask;
	logic [ipv_pkg::NUM_LVL-1:0] next_active_mask;
	logic [ipv_pkg::NUM_LVL-1:0] after_return;
	logic [ipv_pkg::LVL_W-1:0] cur_level;
	logic accept;
	logic next_vector_valid;
	logic [ipv_pkg::VEC_W-1:0] next_vector_addr;
	logic [ipv_pkg::SRC_W-1:0] next_accepted_source;
	logic [ipv_pkg::LVL_W-1:0] next_active_level;
	logic next_in_service;
	always_comb
	begin
		cur_level = top_level(active_mask);
		// preempt only above the running level; level 3 cannot be exceeded
		accept = win_found && (active_mask == ipv_pkg::ACTIVE_RESET
			|| win_level > cur_level);
		after_return = active_mask;
		if (handler_return && active_mask != ipv_pkg::ACTIVE_RESET)
			after_return[cur_level] = 1'b0;
		next_active_mask = after_return;
		next_vector_valid = 1'b0;
		next_vector_addr = vector_addr;
		next_accepted_source = accepted_source;
		if (accept)
		begin
			next_active_mask[win_level] = 1'b1;
			next_vector_valid = 1'b1;
			next_vector_addr = ipv_pkg::VECTOR_TABLE[win_src];
			next_accepted_source = win_src;
		end
		next_active_level = top_level(next_active_mask);
		next_in_service = (next_active_mask != ipv_pkg::ACTIVE_RESET);
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			active_mask <= ipv_pkg::ACTIVE_RESET;
			vector_valid <= 1'b0;
			vector_addr <= ipv_pkg::VECTOR_RESET;
			accepted_source <= ipv_pkg::SRC_EXT0;
			active_level <= ipv_pkg::LEVEL_LOWEST;
			in_service <= 1'b0;
		end
		else
		begin
			active_mask <= next_active_mask;
			vector_valid <= next_vector_valid;
			vector_addr <= next_vector_addr;
			accepted_source <= next_accepted_source;
			active_level <= next_active_level;
			in_service <= next_in_service;
		end
	end

	a_enable_gates_accept: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> $past(source_enable[next_accepted_source]))
		else $error("disabled source was accepted");
	a_valid_needs_request: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> $past(request[next_accepted_source]))
		else $error("accepted source had no request");
	a_global_blocks_all: assert property (@(posedge clock) disable iff (rst)
		!global_enable |=> !vector_valid)
		else $error("accept while global enable clear");
	a_level_from_bits: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> active_level == $past({priority_high_bit[next_accepted_source],
			priority_low_bit[next_accepted_source]}))
		else $error("recorded level does not match priority bits");
	a_preempt_strictly: assert property (@(posedge clock) disable iff (rst)
		(vector_valid && $past(in_service) && !$past(handler_return))
		|-> active_level > $past(active_level))
		else $error("preemption without higher level");
	a_top_level_hold: assert property (@(posedge clock) disable iff (rst)
		(in_service && active_level == ipv_pkg::LEVEL_HIGHEST && !handler_return)
		|=> !vector_valid)
		else $error("highest level handler was preempted");
	a_higher_wins: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> ($past(lvl_seen) >> active_level) == 4'h1)
		else $error("lower level won over higher");
	// all eligible at level 0 with rank one among them: rank one must win
	a_poll_order: assert property (@(posedge clock) disable iff (rst)
		(!in_service && eligible[ipv_pkg::SRC_EXT0] && lvl_seen == 4'h1)
		|=> vector_valid && accepted_source == ipv_pkg::SRC_EXT0)
		else $error("rank one lost among equal levels");
	a_rank_tie: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> !$past(tie_before[next_accepted_source]))
		else $error("later rank won a tie");
	a_vector_map: assert property (@(posedge clock) disable iff (rst)
		vector_valid && accepted_source == ipv_pkg::SRC_PCA |-> vector_addr == 16'h0033)
		else $error("counter array vector wrong");
	a_vector_table: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> vector_addr == ipv_pkg::VECTOR_TABLE[accepted_source])
		else $error("vector does not match accepted source");
	a_uart_merge: assert property (@(posedge clock) disable iff (rst)
		(!in_service && global_enable && source_enable[ipv_pkg::SRC_UART]
		&& uart_tx_done_flag && (eligible & 11'h7df) == 11'h000)
		|=> vector_valid && accepted_source == ipv_pkg::SRC_UART)
		else $error("transmit flag did not request serial service");
	a_can_merge: assert property (@(posedge clock) disable iff (rst)
		(!in_service && global_enable && source_enable[ipv_pkg::SRC_CAN]
		&& (can_recv_ok || can_fault_flag || can_buffer_overrun)
		&& (eligible & 11'h77f) == 11'h000)
		|=> vector_valid && accepted_source == ipv_pkg::SRC_CAN)
		else $error("bus controller flag did not request service");
	a_pca_merge: assert property (@(posedge clock) disable iff (rst)
		(!in_service && global_enable && source_enable[ipv_pkg::SRC_PCA]
		&& (|pca_irq) && (eligible & 11'h7ef) == 11'h000)
		|=> vector_valid && accepted_source == ipv_pkg::SRC_PCA)
		else $error("timer module request did not reach service");
	a_level_release: assert property (@(posedge clock) disable iff (rst)
		(in_service && handler_return && $onehot(active_mask) && !accept)
		|=> !in_service)
		else $error("return did not release the level");
	// a return pops only the innermost level, so what remains is lower
	a_return_lowers: assert property (@(posedge clock) disable iff (rst)
		(handler_return && in_service && !accept)
		|=> !in_service || active_level < $past(active_level))
		else $error("return did not lower the active level");
	a_idle_level_zero: assert property (@(posedge clock) disable iff (rst)
		!in_service |-> active_level == ipv_pkg::LEVEL_LOWEST)
		else $error("level recorded while idle");
	a_accept_in_service: assert property (@(posedge clock) disable iff (rst)
		vector_valid |-> in_service)
		else $error("accept without recorded level");
endmodule // ipv_top

//--- ipv_core_model.sv
// Purpose: stand-in for the processor core that runs interrupt handlers
// Assumes: bench raises ret_req once the handler's request flag is cleared
// Notes: wait_cycles stretches the handler so prompt and slow returns both occur
`timescale 1ns/1ps
module ipv_core_model (
	// system
	input wire logic clock,
	input wire logic rst,
	// bench control
	input wire logic ret_req,
	input wire logic [3:0] wait_cycles,
	// core handshake
	output logic handler_return
);
	logic [3:0] cnt;
	logic sent;
	// one return pulse per request, launched off the falling edge
	always @(negedge clock)
	begin
		handler_return <= 1'b0;
		if (rst || !ret_req)
		begin
			cnt <= 4'h0;
			sent <= 1'b0;
		end
		else if (!sent)
		begin
			if (cnt >= wait_cycles)
			begin
				handler_return <= 1'b1;
				sent <= 1'b1;
			end
			else
				cnt <= cnt + 4'h1;
		end
	end
endmodule // ipv_core_model

//--- ipv_tb.sv
// Purpose: self-checking bench for interrupt priority and vectoring
// Assumes: all inputs change on the falling edge
// Notes: external pins are pre-loaded while blocked, since their synchroniser adds delay
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [10:0] req = 11'h0;
	logic alt_uart = 1'b0;
	logic [2:0] alt_can = 3'h0;
	logic ge = 1'b1;
	logic [10:0] sen = 11'h7ff;
	logic [10:0] ph = 11'h0;
	logic [10:0] pl = 11'h0;
	logic [15:0] cnt = 16'h0;
	logic [79:0] cap = 80'h0;
	logic [4:0] ce = 5'h0;
	logic [4:0] fe = 5'h0;
	logic [4:0] ie = 5'h0;
	logic [4:0] fc = 5'h0;
	logic rr = 1'b0;
	logic [3:0] wc = 4'h0;
	logic handler_return;
	logic [4:0] pca_module_event_flag;
	logic vector_valid;
	logic [15:0] vector_addr;
	logic [3:0] accepted_source;
	logic [1:0] active_level;
	logic in_service;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [15:0] vec_tbl [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033,
		16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
	always #5 clock = ~clock;
	ipv_top u_ipv_top (.clock(clock), .rst(rst), .ext_irq_zero(req[0]), .ext_irq_one(req[2]),
		.timer_zero_overflow(req[1]), .timer_one_overflow(req[3]), .timer_two_overflow(req[6]),
		.uart_rx_done_flag(req[5]), .uart_tx_done_flag(alt_uart), .can_send_ok(req[7]),
		.can_recv_ok(alt_can[0]), .can_fault_flag(alt_can[1]), .can_buffer_overrun(alt_can[2]),
		.converter_done_flag(req[8]), .can_timer_wrap_flag(req[9]), .spi_irq_flag(req[10]),
		.pca_counter_overflow_flag(req[4]), .pca_counter(cnt), .pca_capture(cap),
		.comparator_enable(ce), .flag_on_equal(fe), .pca_module_irq_enable(ie),
		.pca_flag_clear(fc), .pca_module_event_flag(pca_module_event_flag),
		.global_enable(ge), .source_enable(sen), .priority_high_bit(ph), .priority_low_bit(pl),
		.handler_return(handler_return), .vector_valid(vector_valid), .vector_addr(vector_addr),
		.accepted_source(accepted_source), .active_level(active_level), .in_service(in_service));
	ipv_core_model u_ipv_core_model (.clock(clock), .rst(rst), .ret_req(rr), .wait_cycles(wc),
		.handler_return(handler_return));
	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task expect_accept(input int src, input logic [1:0] lvl);
		int k;
		for (k = 0; k < 12; k++)
		begin
			@(posedge clock);
			#1;
			if (vector_valid === 1'b1)
				break;
		end
		check(vector_valid, 1'b1);
		check(vector_addr, vec_tbl[src]);
		check(accepted_source, src[3:0]);
		check(active_level, lvl);
		@(negedge clock);
	endtask
	task expect_none(input int n);
		repeat (n)
		begin
			@(posedge clock);
			#1;
			check(vector_valid, 1'b0);
		end
		@(negedge clock);
	endtask
	// core return; the flag must already be low or it is retaken at once
	// one idle cycle first so a dropped pin has left its synchroniser
	task ret;
		int k;
		@(negedge clock);
		rr <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(negedge clock);
			if (handler_return === 1'b1)
				break;
		end
		rr <= 1'b0;
		check(handler_return, 1'b1);
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			end_sim();
		end
	end
	initial
	begin
		repeat (8) @(negedge clock);
		rst = 1'b0;
		// each source alone, cycling through the four level codes
		for (int i = 0; i < 11; i++)
		begin
			ph[i] = i[1];
			pl[i] = i[0];
			req[i] = 1'b1;
			wc = i[0] ? 4'h5 : 4'h0;
			expect_accept(i, i[1:0]);
			req[i] = 1'b0;
			ret();
			check(in_service, 1'b0);
			check(active_level, 2'h0);
		end
		ph = 11'h0;
		pl = 11'h0;
		alt_uart = 1'b1;
		expect_accept(5, 2'h0);
		alt_uart = 1'b0;
		ret();
		for (int j = 0; j < 3; j++)
		begin
			alt_can[j] = 1'b1;
			expect_accept(7, 2'h0);
			alt_can[j] = 1'b0;
			ret();
		end
		// blocked by source enables, then by the global enable
		sen = 11'h0;
		req = 11'h7ff;
		expect_none(6);
		sen = 11'h7ff;
		ge = 1'b0;
		expect_none(6);
		ge = 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			expect_accept(i, 2'h0);
			req[i] = 1'b0;
			ret();
		end
		// levels: 10 and 9 at 3, 5 at 2, 1 and 3 at 1
		ph = 11'h620;
		pl = 11'h60a;
		req[10] = 1'b1;
		req[1] = 1'b1;
		expect_accept(10, 2'h3);
		req[10] = 1'b0;
		req[9] = 1'b1;
		req[5] = 1'b1;
		expect_none(5);
		req[9] = 1'b0;
		ret();
		expect_accept(5, 2'h2);
		req[5] = 1'b0;
		ret();
		expect_accept(1, 2'h1);
		req[3] = 1'b1;
		expect_none(5);
		req[5] = 1'b1;
		expect_accept(5, 2'h2);
		req[5] = 1'b0;
		ret();
		check(active_level, 2'h1);
		req[1] = 1'b0;
		ret();
		expect_accept(3, 2'h1);
		req[3] = 1'b0;
		ret();
		// counter-array module 0 as a software timer
		ph = 11'h0;
		pl = 11'h0;
		cap = {64'h0, 16'h1234};
		ce = 5'h01;
		cnt = 16'h1234;
		@(negedge clock);
		cnt = 16'h0;
		@(negedge clock);
		check(pca_module_event_flag, 5'h00);
		fe = 5'h01;
		cnt = 16'h1234;
		@(negedge clock);
		cnt = 16'h1235;
		@(negedge clock);
		check(pca_module_event_flag, 5'h01);
		expect_none(4);
		ie = 5'h01;
		expect_accept(4, 2'h0);
		fc = 5'h01;
		@(negedge clock);
		fc = 5'h00;
		@(negedge clock);
		check(pca_module_event_flag, 5'h00);
		ie = 5'h00;
		ret();
		check(in_service, 1'b0);
		// match and clear in one cycle: the match wins
		fc = 5'h01;
		cnt = 16'h1234;
		@(negedge clock);
		fc = 5'h00;
		cnt = 16'h0;
		@(negedge clock);
		check(pca_module_event_flag, 5'h01);
		fc = 5'h01;
		@(negedge clock);
		fc = 5'h00;
		ce = 5'h00;
		cnt = 16'h1234;
		@(negedge clock);
		cnt = 16'h0;
		@(negedge clock);
		check(pca_module_event_flag, 5'h00);
		end_sim();
	end
endmodule // testbench
